/* rtl/dacc_pkg.sv */
/*
  Shared constants for the accumulator datapath: register map, field positions,
  reset values, operation codes and saturation limits.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package dacc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRAP = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ACCUMULATOR_FIRST_LO = 8'h0C;
  localparam logic [7:0] ADDR_ACCUMULATOR_FIRST_HI = 8'h10;
  localparam logic [7:0] ADDR_ACCUMULATOR_SECOND_LO = 8'h14;
  localparam logic [7:0] ADDR_ACCUMULATOR_SECOND_HI = 8'h18;

  // control register fields
  localparam int CTRL_SAT_A = 7;
  localparam int CTRL_SAT_B = 6;
  localparam int CTRL_WSAT = 5;
  localparam int CTRL_SUPER = 4;
  localparam int CTRL_RND = 1;
  localparam logic [7:0] CTRL_MASK = 8'hF2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // trap enable fields
  localparam int TRAP_A = 0;
  localparam int TRAP_B = 1;
  localparam int TRAP_CAT = 2;
  localparam logic [2:0] TRAP_RESET = 3'h0;

  // status fields; writing one to a sticky bit clears it
  localparam int STAT_GUARD_A = 0;
  localparam int STAT_GUARD_B = 1;
  localparam int STAT_SAT_A = 2;
  localparam int STAT_SAT_B = 3;
  localparam int STAT_ANY_GUARD = 4;
  localparam int STAT_ANY_SAT = 5;

  // saturation limits, rounding half point, write-back pointer step and shift clamp
  localparam logic [39:0] SAT9_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT9_NEG = 40'h80_0000_0000;
  localparam logic [39:0] SAT1_POS = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT1_NEG = 40'hFF_8000_0000;
  localparam logic [15:0] WSAT_POS = 16'h7FFF;
  localparam logic [15:0] WSAT_NEG = 16'h8000;
  localparam logic [15:0] RND_HALF = 16'h8000;
  localparam logic [15:0] WB_PTR_STEP = 16'h0002;
  localparam logic [5:0] SHIFT_MAX = 6'h10;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_LOAD = 4'h2,
    OP_MAC = 4'h3,
    OP_MSC = 4'h4,
    OP_MPY = 4'h5,
    OP_MPYN = 4'h6,
    OP_ED = 4'h7,
    OP_EUCLIDEAN_DISTANCE_ACCUMULATE_OP = 4'h8,
    OP_CLR = 4'h9,
    OP_MOVSAC = 4'hA,
    OP_SACT = 4'hB,
    OP_SACR = 4'hC,
    OP_SHIFT = 4'hD,
    OP_MCUSH = 4'hE,
    OP_NOP = 4'hF
  } dacc_op_t;

endpackage

/* rtl/dacc_datapath.sv */
/*
  Accumulator datapath: 40-bit adder/subtracter with overflow and saturation,
  sticky flags and trap request, round and write saturation for stores and
  write-back, and the 40-bit barrel shifter. Control bits sit behind a
  classic Wishbone slave.
  Assumes the sequencer presents one operation per cycle with opValid high for
  exactly that cycle, and that shift amounts stay within -16..16.
*/
// The implementer's own choices: the register addresses and the Wishbone register port.
// Functional notes
// - 40-bit adder; optional zero input; subtract complements operand, borrow-in active low.
// - every adder pass sets guard flag when bits 39:32 differ, else clears.
// - signed overflow out of bit 39 (same-sign operands, sum sign differs) is flagged as catastrophic overflow.
// - guard flag becoming set with its trap enable raises a trap request.
// - saturation flags only set by hardware; stay set until software clears.
// - saturation off: flag records bit 39 overflow; may trap with catastrophic enable.
// - combined flags are OR of both guard flags and of both saturation flags.
// - saturation decided from sum, overflow, enables bits 7:6 and width bit 4.
// - super mode: bit 39 overflow loads 9.31 limit and sets sticky flag.
// - normal mode: bit 31 overflow loads 1.31 limit; guard flags never set.
// - catastrophic mode wraps, still sets sticky flag and may trap.
// - multiply-accumulate class may write rounded non-target high word to data space.
// - write-back goes to working register or pointed address; pointer then plus 2.
// - combinational round gives 1.15 value; no rounding truncates high word.
// - conventional rounding adds bit 15 to high word.
// - convergent: low word exactly 0x8000 rounds up only if bit 16 set.
// - truncating store unrounded, rounding store rounded; write-back always rounded.
// - write saturation clamps to 0x7FFF or 0x8000, accumulator untouched.
// - write saturation takes sign from bit 39 plus round adder overflow.
// - write saturation off passes rounded or truncated word unmodified.
// - shifter moves operand up to 16 bits; positive right, negative left.
// - X bus enters at 31:16 for right, 15:0 for left; 40 or 16-bit results.
module dacc_datapath #(
  parameter int ACC_W = 40,
  parameter int WORD_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic opTarget,
  input wire logic [ACC_W-1:0] opOperand,
  input wire logic opWriteBack,
  input wire logic opWbIndirect,
  input wire logic [WORD_W-1:0] wbPointer,
  input wire logic [5:0] shiftAmount,
  input wire logic shiftFromX,
  input wire logic shiftLogical,
  input wire logic [WORD_W-1:0] xBusIn,
  output logic [ACC_W-1:0] accumulatorFirst,
  output logic [ACC_W-1:0] accumulatorSecond,
  output logic accAGuardOverflow,
  output logic accBGuardOverflow,
  output logic accASaturatedSticky,
  output logic accBSaturatedSticky,
  output logic anyGuardOverflow,
  output logic anySaturated,
  output logic trapRequest,
  output logic wbWregWrite,
  output logic wbMemWrite,
  output logic [WORD_W-1:0] wbData,
  output logic [WORD_W-1:0] wbAddr,
  output logic wbPointerWrite,
  output logic [WORD_W-1:0] wbPointerNext,
  output logic [WORD_W-1:0] mcuShiftResult
);

  // 1.15 store word: optional round, then optional write saturation
  function automatic logic [15:0] storeWord(input logic [39:0] acc, input logic doRound,
                                            input logic conv, input logic satOn);
    logic inc;
    logic [24:0] wide;
    logic satPos;
    logic satNeg;
    inc = doRound & acc[15] & ((acc[15:0] != dacc_pkg::RND_HALF) | conv | acc[16]);
    wide = {acc[39], acc[39:16]} + {24'h000000, inc};
    satPos = ~acc[39] & (wide[24:15] != 10'h000);
    satNeg = acc[39] & (wide[24:15] != 10'h3FF);
    if (satOn && satPos) begin
      storeWord = dacc_pkg::WSAT_POS;
    end else if (satOn && satNeg) begin
      storeWord = dacc_pkg::WSAT_NEG;
    end else begin
      storeWord = wide[15:0];
    end
  endfunction

  function automatic logic guardMixed(input logic [7:0] g);
    guardMixed = ~((&g) | ~(|g));
  endfunction

  logic [ACC_W-1:0] accAFf, accBFf;
  logic guardAFf, guardBFf, satAFf, satBFf, trapReqFf;
  logic [7:0] ctrlFf;
  logic [2:0] trapEnFf;
  logic ackFf;
  logic [31:0] datOFf;
  logic wbWregFf, wbMemFf;
  logic [WORD_W-1:0] wbDataFf, wbAddrFf, wbPtrNextFf, mcuShiftFf;

  // register bus decode
  wire busReq = wb_cyc_i & wb_stb_i & ~ackFf;
  wire busWr = busReq & wb_we_i & wb_sel_i[0];
  wire wrCtrl = busWr & (wb_adr_i == dacc_pkg::ADDR_CTRL);
  wire wrTrap = busWr & (wb_adr_i == dacc_pkg::ADDR_TRAP);
  wire wrStat = busWr & (wb_adr_i == dacc_pkg::ADDR_STAT);
  wire clrSatA = wrStat & wb_dat_i[dacc_pkg::STAT_SAT_A];
  wire clrSatB = wrStat & wb_dat_i[dacc_pkg::STAT_SAT_B];
  wire [5:0] statVec = {anySaturated, anyGuardOverflow, satBFf, satAFf, guardBFf, guardAFf};
  logic [31:0] rdData;
  always_comb begin
    case (wb_adr_i)
      dacc_pkg::ADDR_CTRL: rdData = {24'h000000, ctrlFf};
      dacc_pkg::ADDR_TRAP: rdData = {29'h00000000, trapEnFf};
      dacc_pkg::ADDR_STAT: rdData = {26'h0000000, statVec};
      dacc_pkg::ADDR_ACCUMULATOR_FIRST_LO: rdData = accAFf[31:0];
      dacc_pkg::ADDR_ACCUMULATOR_FIRST_HI: rdData = {24'h000000, accAFf[39:32]};
      dacc_pkg::ADDR_ACCUMULATOR_SECOND_LO: rdData = accBFf[31:0];
      dacc_pkg::ADDR_ACCUMULATOR_SECOND_HI: rdData = {24'h000000, accBFf[39:32]};
      default: rdData = 32'h00000000;
    endcase
  end

  // operation decode
  wire isShift = (opCode == dacc_pkg::OP_SHIFT);
  wire isClr = (opCode == dacc_pkg::OP_CLR);
  wire usesAdder = opValid & (opCode <= dacc_pkg::OP_CLR | isShift);
  wire zeroIn = (opCode == dacc_pkg::OP_LOAD) | (opCode == dacc_pkg::OP_MPY) | (opCode == dacc_pkg::OP_MPYN) |
                (opCode == dacc_pkg::OP_ED) | isClr | isShift;
  wire subOp = (opCode == dacc_pkg::OP_SUB) | (opCode == dacc_pkg::OP_MSC) | (opCode == dacc_pkg::OP_MPYN);
  wire wbClass = (opCode == dacc_pkg::OP_MAC) | (opCode == dacc_pkg::OP_MSC) | isClr |
                 (opCode == dacc_pkg::OP_MOVSAC);
  wire storeOp = opValid & ((opCode == dacc_pkg::OP_SACT) | (opCode == dacc_pkg::OP_SACR));
  wire macWb = opValid & wbClass & opWriteBack;
  wire wbFire = macWb | storeOp;
  wire [ACC_W-1:0] accSel = opTarget ? accBFf : accAFf;
  wire [ACC_W-1:0] accOther = opTarget ? accAFf : accBFf;

  // barrel shifter
  wire [5:0] shiftMag = shiftAmount[5] ? 6'(-shiftAmount) : shiftAmount;
  wire [5:0] shiftClamp = (shiftMag > dacc_pkg::SHIFT_MAX) ? dacc_pkg::SHIFT_MAX : shiftMag;
  wire shiftRight = ~shiftAmount[5] & (shiftAmount != 6'h00);
  wire shiftLeft = shiftAmount[5];
  wire [ACC_W-1:0] xRightIn = {{8{xBusIn[15]}}, xBusIn, 16'h0000};
  wire [ACC_W-1:0] xLeftIn = {{24{xBusIn[15]}}, xBusIn};
  wire [ACC_W-1:0] shiftSrc = shiftFromX ? (shiftRight ? xRightIn : xLeftIn) : accSel;
  wire shiftFill = shiftSrc[39] & ~shiftLogical;
  wire [79:0] rightExt = {{40{shiftFill}}, shiftSrc} >> shiftClamp;
  wire [ACC_W-1:0] shiftOut = shiftRight ? rightExt[39:0] :
                              (shiftLeft ? (shiftSrc << shiftClamp) : shiftSrc);
  wire [WORD_W-1:0] mcuWord = shiftRight ? shiftOut[31:16] : shiftOut[15:0];

  // adder/subtracter
  wire [ACC_W-1:0] adderA = zeroIn ? '0 : accSel;
  wire [ACC_W-1:0] adderTrue = isShift ? shiftOut : (isClr ? '0 : opOperand);
  wire [ACC_W-1:0] adderB = subOp ? ~adderTrue : adderTrue;
  wire carryIn = subOp;
  wire [ACC_W-1:0] sum = adderA + adderB + {39'h0000000000, carryIn};
  wire catOvf = (adderA[39] == adderB[39]) & (sum[39] != adderA[39]);
  wire bit31Ovf = catOvf | ~((&sum[39:31]) | ~(|sum[39:31]));
  wire trueNeg = catOvf ? adderA[39] : sum[39];

  // saturation
  wire satOn = opTarget ? ctrlFf[dacc_pkg::CTRL_SAT_B] : ctrlFf[dacc_pkg::CTRL_SAT_A];
  wire superMode = ctrlFf[dacc_pkg::CTRL_SUPER];
  wire doSat = satOn & (superMode ? catOvf : bit31Ovf);
  wire [ACC_W-1:0] satValue = superMode ? (trueNeg ? dacc_pkg::SAT9_NEG : dacc_pkg::SAT9_POS) :
                                          (trueNeg ? dacc_pkg::SAT1_NEG : dacc_pkg::SAT1_POS);
  wire [ACC_W-1:0] newAcc = doSat ? satValue : sum;
  // guard taken from the written value, so a 1.31 clamp never shows a guard overflow
  wire newGuard = guardMixed(newAcc[39:32]);
  wire satEvent = satOn ? doSat : catOvf;
  wire oldGuard = opTarget ? guardBFf : guardAFf;
  wire guardTrapEn = opTarget ? trapEnFf[dacc_pkg::TRAP_B] : trapEnFf[dacc_pkg::TRAP_A];
  wire trapNow = usesAdder & ((newGuard & ~oldGuard & guardTrapEn) |
                              (~satOn & catOvf & trapEnFf[dacc_pkg::TRAP_CAT]));
  wire updA = usesAdder & ~opTarget;
  wire updB = usesAdder & opTarget;

  // store and write-back word
  wire [ACC_W-1:0] wbSrc = storeOp ? accSel : accOther;
  wire wbRound = macWb | (opCode == dacc_pkg::OP_SACR);
  wire [WORD_W-1:0] wbWord = storeWord(wbSrc, wbRound, ctrlFf[dacc_pkg::CTRL_RND], ctrlFf[dacc_pkg::CTRL_WSAT]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accAFf <= '0;
      accBFf <= '0;
      guardAFf <= 1'b0;
      guardBFf <= 1'b0;
    end else begin
      if (updA) begin
        accAFf <= newAcc;
        guardAFf <= newGuard;
      end
      if (updB) begin
        accBFf <= newAcc;
        guardBFf <= newGuard;
      end
    end
  end

  // set wins over a software clear arriving in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      satAFf <= 1'b0;
      satBFf <= 1'b0;
      trapReqFf <= 1'b0;
    end else begin
      satAFf <= (updA & satEvent) | (satAFf & ~clrSatA);
      satBFf <= (updB & satEvent) | (satBFf & ~clrSatB);
      trapReqFf <= trapNow;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlFf <= dacc_pkg::CTRL_RESET;
      trapEnFf <= dacc_pkg::TRAP_RESET;
      ackFf <= 1'b0;
      datOFf <= 32'h00000000;
    end else begin
      ackFf <= busReq;
      if (busReq) begin
        datOFf <= rdData;
      end
      if (wrCtrl) begin
        ctrlFf <= wb_dat_i[7:0] & dacc_pkg::CTRL_MASK;
      end
      if (wrTrap) begin
        trapEnFf <= wb_dat_i[2:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wbWregFf <= 1'b0;
      wbMemFf <= 1'b0;
      wbDataFf <= '0;
      wbAddrFf <= '0;
      wbPtrNextFf <= '0;
      mcuShiftFf <= '0;
    end else begin
      wbWregFf <= wbFire & ~opWbIndirect;
      wbMemFf <= wbFire & opWbIndirect;
      if (wbFire) begin
        wbDataFf <= wbWord;
        wbAddrFf <= wbPointer;
        wbPtrNextFf <= wbPointer + dacc_pkg::WB_PTR_STEP;
      end
      if (opValid && opCode == dacc_pkg::OP_MCUSH) begin
        mcuShiftFf <= mcuWord;
      end
    end
  end

  assign wb_ack_o = ackFf;
  assign wb_dat_o = datOFf;
  assign accumulatorFirst = accAFf;
  assign accumulatorSecond = accBFf;
  assign accAGuardOverflow = guardAFf;
  assign accBGuardOverflow = guardBFf;
  assign accASaturatedSticky = satAFf;
  assign accBSaturatedSticky = satBFf;
  assign anyGuardOverflow = guardAFf | guardBFf;
  assign anySaturated = satAFf | satBFf;
  assign trapRequest = trapReqFf;
  assign wbWregWrite = wbWregFf;
  assign wbMemWrite = wbMemFf;
  assign wbData = wbDataFf;
  assign wbAddr = wbAddrFf;
  assign wbPointerWrite = wbMemFf;
  assign wbPointerNext = wbPtrNextFf;
  assign mcuShiftResult = mcuShiftFf;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence sAccAPass;
    opValid && !opTarget && usesAdder;
  endsequence

  a_adder_add_path: assert property (
    sAccAPass and (opCode == dacc_pkg::OP_ADD) && !ctrlFf[dacc_pkg::CTRL_SAT_A]
    |=> accumulatorFirst == 40'($past(accAFf) + $past(opOperand)))
    else $error("add result wrong");
  a_guard_flag_value: assert property (
    sAccAPass |=> accAGuardOverflow == guardMixed(accumulatorFirst[39:32]))
    else $error("guard flag disagrees with accumulator");
  a_sticky_sat_hold: assert property (
    accASaturatedSticky && !clrSatA |=> accASaturatedSticky)
    else $error("sticky saturation lost");
  a_guard_trap_req: assert property (
    $rose(accAGuardOverflow) && $past(trapEnFf[dacc_pkg::TRAP_A]) |-> trapRequest)
    else $error("guard trap missing");
  a_super_sat_load: assert property (
    sAccAPass and catOvf && ctrlFf[dacc_pkg::CTRL_SAT_A] && superMode
    |=> (accumulatorFirst == dacc_pkg::SAT9_POS || accumulatorFirst == dacc_pkg::SAT9_NEG) && accASaturatedSticky)
    else $error("super saturation wrong");
  a_normal_no_guard: assert property (
    sAccAPass and ctrlFf[dacc_pkg::CTRL_SAT_A] && !superMode |=> !accAGuardOverflow)
    else $error("guard set in normal saturation");
  a_cat_wrap_flag: assert property (
    sAccAPass and catOvf && !ctrlFf[dacc_pkg::CTRL_SAT_A]
    |=> accumulatorFirst == $past(sum) && accASaturatedSticky)
    else $error("catastrophic overflow not recorded");
  a_cat_trap_req: assert property (
    usesAdder && catOvf && !satOn && trapEnFf[dacc_pkg::TRAP_CAT] |=> trapRequest)
    else $error("catastrophic trap missing");
  a_combined_flags: assert property (
    anySaturated == (accASaturatedSticky || accBSaturatedSticky) &&
    anyGuardOverflow == (accAGuardOverflow || accBGuardOverflow))
    else $error("combined flag wrong");
  a_wsat_pos_clamp: assert property (
    storeOp && ctrlFf[dacc_pkg::CTRL_WSAT] && !accSel[39] && (accSel[38:31] != 8'h00)
    |=> wbData == dacc_pkg::WSAT_POS && $stable(accumulatorFirst) && $stable(accumulatorSecond))
    else $error("write saturation clamp wrong");
  a_wb_ptr_step: assert property (
    wbMemWrite |-> wbPointerNext == 16'(wbAddr + dacc_pkg::WB_PTR_STEP) && !wbWregWrite)
    else $error("pointer step wrong");
  a_trunc_store: assert property (
    storeOp && opCode == dacc_pkg::OP_SACT && !ctrlFf[dacc_pkg::CTRL_WSAT]
    |=> wbData == $past(accSel[31:16]))
    else $error("truncated store wrong");

endmodule // dacc_datapath

/* bench/dacc_xbus_model.sv */
/*
  X bus side of the accumulator datapath: working register, word memory and
  the write-back pointer that the datapath post-increments.
  Assumes single-cycle write strobes from the datapath on mclk.
*/
module dacc_xbus_model #(
  parameter logic [15:0] PTR_INIT = 16'h0100
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wbWregWrite,
  input wire logic wbMemWrite,
  input wire logic wbPointerWrite,
  input wire logic [15:0] wbData,
  input wire logic [15:0] wbAddr,
  input wire logic [15:0] wbPointerNext,
  output logic [15:0] wbPointer,
  output logic [15:0] workReg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ptr_ff;
  logic [15:0] wreg_ff;
  logic [15:0] mem [0:255];
  assign wbPointer = ptr_ff;
  assign workReg = wreg_ff;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  end
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= PTR_INIT;
      wreg_ff <= 16'h0000;
    end else begin
      if (wbPointerWrite) ptr_ff <= wbPointerNext;
      if (wbWregWrite) wreg_ff <= wbData;
      // word memory; byte address bit 0 ignored
      if (wbMemWrite) mem[wbAddr[8:1]] <= wbData;
    end
  end
endmodule // dacc_xbus_model

/* bench/tb.sv */
/*
  Self-checking bench: a table of load-then-operate rows, then hand tests
  for write-back, sticky flags, register bus and reset.
  Assumes dacc_datapath, the X bus model and a 40 MHz clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] c;
    logic [3:0] op;
    logic [39:0] ld, nd;
    logic [6:0] sh;
    logic [39:0] ea;
    logic [2:0] ef;
    logic [15:0] ew;
  } dacc_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic opValid = 1'b0, opTarget = 1'b0, opWriteBack = 1'b0, opWbIndirect = 1'b0;
  logic [3:0] opCode = 4'hF;
  logic [39:0] opOperand = 40'h0, accumulatorFirst, accumulatorSecond;
  logic [15:0] xBusIn = 16'h0, wbPointer, wbData, wbAddr, wbPointerNext, mcuShiftResult, workReg, p0;
  logic [5:0] shiftAmount = 6'h00;
  logic shiftFromX = 1'b0, shiftLogical = 1'b0;
  logic accAGuardOverflow, accBGuardOverflow, accASaturatedSticky, accBSaturatedSticky;
  logic anyGuardOverflow, anySaturated, trapRequest, wbWregWrite, wbMemWrite, wbPointerWrite;
  int num_errors = 0, checked = 0, cycles = 0;
  // ctrl, op, load value, operand, {fromX, shift}, acc, {guard, sticky, trap}, stored word
  dacc_row_t rows [] = '{
    '{8'h00, dacc_pkg::OP_ADD, 40'h7F_FFFF_FFFF, 40'h1, 7'h00, 40'h80_0000_0000, 3'h7, 16'h0},
    '{8'h90, dacc_pkg::OP_ADD, 40'h7F_FFFF_FFFF, 40'h1, 7'h00, 40'h7F_FFFF_FFFF, 3'h6, 16'h0},
    '{8'h80, dacc_pkg::OP_ADD, 40'h00_7FFF_FFFF, 40'h1, 7'h00, 40'h00_7FFF_FFFF, 3'h2, 16'h0},
    '{8'h80, dacc_pkg::OP_SUB, 40'hFF_8000_0000, 40'h1, 7'h00, 40'hFF_8000_0000, 3'h2, 16'h0},
    '{8'h90, dacc_pkg::OP_SUB, 40'h80_0000_0000, 40'h1, 7'h00, 40'h80_0000_0000, 3'h6, 16'h0},
    '{8'h00, dacc_pkg::OP_ADD, 40'h00_FFFF_FFFF, 40'h1, 7'h00, 40'h01_0000_0000, 3'h5, 16'h0},
    '{8'h00, dacc_pkg::OP_SUB, 40'h10, 40'h3, 7'h00, 40'hD, 3'h0, 16'h0},
    '{8'h80, dacc_pkg::OP_ADD, 40'h00_7FFF_0000, 40'hFFFF, 7'h00, 40'h00_7FFF_FFFF, 3'h0, 16'h0},
    '{8'h02, dacc_pkg::OP_SACR, 40'h00_1234_8000, 40'h0, 7'h00, 40'h00_1234_8000, 3'h0, 16'h1235},
    '{8'h00, dacc_pkg::OP_SACR, 40'h00_1234_8000, 40'h0, 7'h00, 40'h00_1234_8000, 3'h0, 16'h1234},
    '{8'h00, dacc_pkg::OP_SACR, 40'h00_1235_8000, 40'h0, 7'h00, 40'h00_1235_8000, 3'h0, 16'h1236},
    '{8'h02, dacc_pkg::OP_SACR, 40'h00_1234_7FFF, 40'h0, 7'h00, 40'h00_1234_7FFF, 3'h0, 16'h1234},
    '{8'h00, dacc_pkg::OP_SACR, 40'h00_1234_8001, 40'h0, 7'h00, 40'h00_1234_8001, 3'h0, 16'h1235},
    '{8'h02, dacc_pkg::OP_SACT, 40'h00_1234_FFFF, 40'h0, 7'h00, 40'h00_1234_FFFF, 3'h0, 16'h1234},
    '{8'h20, dacc_pkg::OP_SACT, 40'h01_1234_0000, 40'h0, 7'h00, 40'h01_1234_0000, 3'h0, 16'h7FFF},
    '{8'h20, dacc_pkg::OP_SACT, 40'hFE_0000_0000, 40'h0, 7'h00, 40'hFE_0000_0000, 3'h0, 16'h8000},
    '{8'h00, dacc_pkg::OP_SACT, 40'h01_1234_0000, 40'h0, 7'h00, 40'h01_1234_0000, 3'h0, 16'h1234},
    '{8'h22, dacc_pkg::OP_SACR, 40'h00_7FFF_8000, 40'h0, 7'h00, 40'h00_7FFF_8000, 3'h0, 16'h7FFF},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'h00_1234_0000, 40'h0, 7'h10, 40'h00_0000_1234, 3'h0, 16'h0},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'h00_0000_1234, 40'h0, 7'h30, 40'h00_1234_0000, 3'h0, 16'h0},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'hFF_0000_0000, 40'h0, 7'h08, 40'hFF_FF00_0000, 3'h0, 16'h0},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'h00_0000_1234, 40'h0, 7'h00, 40'h00_0000_1234, 3'h0, 16'h0},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'h0, 40'h1234, 7'h44, 40'h00_0123_4000, 3'h0, 16'h0},
    '{8'h00, dacc_pkg::OP_SHIFT, 40'h0, 40'h1234, 7'h7C, 40'h00_0001_2340, 3'h0, 16'h0}
  };
  always #12.5 mclk = ~mclk;
  dacc_datapath dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .opValid, .opCode, .opTarget, .opOperand, .opWriteBack, .opWbIndirect,
    .wbPointer, .shiftAmount, .shiftFromX, .shiftLogical, .xBusIn, .accumulatorFirst, .accumulatorSecond,
    .accAGuardOverflow, .accBGuardOverflow, .accASaturatedSticky, .accBSaturatedSticky, .anyGuardOverflow,
    .anySaturated, .trapRequest, .wbWregWrite, .wbMemWrite, .wbData, .wbAddr, .wbPointerWrite,
    .wbPointerNext, .mcuShiftResult);
  dacc_xbus_model model (.mclk, .rst_n, .wbWregWrite, .wbMemWrite, .wbPointerWrite, .wbData, .wbAddr,
    .wbPointerNext, .wbPointer, .workReg);
  task automatic stop_test;
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    // look just after each edge, so ack seen here is what the next edge samples
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(wb_ack_o, 1'b1);
    @(posedge mclk);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic op(input logic [3:0] c, input logic t, input logic [39:0] d, input logic [6:0] s,
    input logic [1:0] w);
    @(posedge mclk);
    {opValid, opCode, opTarget, opOperand, xBusIn} <= {1'b1, c, t, d, d[15:0]};
    {shiftFromX, shiftAmount, opWriteBack, opWbIndirect} <= {s, w};
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, dacc_pkg::ADDR_CTRL, 32'h0, q);
    chk(q, 40'(dacc_pkg::CTRL_RESET));
    bus(1'b0, dacc_pkg::ADDR_TRAP, 32'h0, q);
    chk(q, 40'(dacc_pkg::TRAP_RESET));
    bus(1'b1, dacc_pkg::ADDR_CTRL, 32'hFF, q);
    bus(1'b0, dacc_pkg::ADDR_CTRL, 32'h0, q);
    chk(q, 40'(dacc_pkg::CTRL_MASK));
    bus(1'b0, 8'h40, 32'h0, q);
    chk(q, 40'h0);
    bus(1'b1, dacc_pkg::ADDR_TRAP, 32'h7, q);
    foreach (rows[i]) begin
      bus(1'b1, dacc_pkg::ADDR_CTRL, {24'h0, rows[i].c}, q);
      op(dacc_pkg::OP_LOAD, 1'b0, rows[i].ld, 7'h00, 2'b01);
      bus(1'b1, dacc_pkg::ADDR_STAT, 32'hC, q);
      op(rows[i].op, 1'b0, rows[i].nd, rows[i].sh, 2'b01);
      chk(accumulatorFirst, rows[i].ea);
      if (rows[i].op inside {dacc_pkg::OP_SACT, dacc_pkg::OP_SACR})
        chk(wbData, rows[i].ew);
      else if (rows[i].op != dacc_pkg::OP_SHIFT)
        chk({anyGuardOverflow, anySaturated, accAGuardOverflow, accASaturatedSticky, trapRequest},
          {rows[i].ef[2:1], rows[i].ef});
    end
    bus(1'b1, dacc_pkg::ADDR_CTRL, 32'h2, q);
    op(dacc_pkg::OP_LOAD, 1'b1, 40'h00_1234_8000, 7'h00, 2'b00);
    op(dacc_pkg::OP_CLR, 1'b0, 40'h0, 7'h00, 2'b00);
    p0 = wbPointer;
    op(dacc_pkg::OP_MAC, 1'b0, 40'h5, 7'h00, 2'b11);
    chk(accumulatorFirst, 40'h5);
    chk(accumulatorSecond, 40'h00_1234_8000);
    chk(wbAddr, p0);
    @(posedge mclk);
    #1;
    chk(model.mem[p0[8:1]], 16'h1235);
    chk(wbPointer, p0 + dacc_pkg::WB_PTR_STEP);
    op(dacc_pkg::OP_MAC, 1'b0, 40'h0, 7'h00, 2'b10);
    op(dacc_pkg::OP_MPY, 1'b0, 40'h7, 7'h00, 2'b11);
    chk(workReg, 16'h1235);
    @(posedge mclk);
    #1;
    chk(wbPointer, p0 + dacc_pkg::WB_PTR_STEP);
    op(dacc_pkg::OP_MCUSH, 1'b0, 40'h1234, 7'h44, 2'b00);
    chk(mcuShiftResult, 16'h0123);
    bus(1'b1, dacc_pkg::ADDR_CTRL, 32'h0, q);
    op(dacc_pkg::OP_LOAD, 1'b0, 40'h7F_FFFF_FFFF, 7'h00, 2'b00);
    op(dacc_pkg::OP_ADD, 1'b0, 40'h1, 7'h00, 2'b00);
    bus(1'b0, dacc_pkg::ADDR_ACCUMULATOR_FIRST_HI, 32'h0, q);
    chk(q, 40'h80);
    op(dacc_pkg::OP_LOAD, 1'b0, 40'h0, 7'h00, 2'b00);
    bus(1'b0, dacc_pkg::ADDR_STAT, 32'h0, q);
    chk(q, 40'h24);
    bus(1'b1, dacc_pkg::ADDR_STAT, 32'h4, q);
    bus(1'b0, dacc_pkg::ADDR_STAT, 32'h0, q);
    chk(q, 40'h0);
    // asynchronous reset in mid-run clears state before the next edge
    op(dacc_pkg::OP_LOAD, 1'b0, 40'h9, 7'h00, 2'b00);
    rst_n <= 1'b0;
    #2;
    chk(accumulatorFirst, 40'h0);
    chk({anySaturated, anyGuardOverflow, trapRequest}, 3'h0);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(accumulatorFirst, 40'h0);
    chk({wb_ack_o, anySaturated, anyGuardOverflow, trapRequest, wbMemWrite}, 5'h0);
    stop_test();
  end
endmodule // tb
